// ==== emb_pkg.sv ====
package emb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // address space layout
    localparam int          ADDR_W         = 13;
    localparam int          DATA_W         = 8;
    localparam int          SPACE_BYTES    = 8192;
    localparam int          PAGE0_BYTES    = 256;
    localparam int          UPPER_BYTES    = 7936;
    localparam logic [12:0] IO_LAST        = 13'h001F;   // 32-byte i/o region
    localparam logic [12:0] EXT0_FIRST     = 13'h0020;   // external part of page zero
    localparam logic [12:0] EXT0_LAST      = 13'h009F;   // 128 locations
    localparam logic [12:0] RAM_FIRST      = 13'h00A0;   // 96 bytes internal ram
    localparam logic [12:0] RAM_LAST       = 13'h00FF;
    localparam logic [12:0] PAGE0_LAST     = 13'h00FF;
    // 22 implemented i/o and timer locations, 10 unused
    localparam logic [31:0] IO_USED_MASK   = 32'h003F_FFFF;

    ////////////////////////////////////////////////////////////////////////////////
    // clock division
    localparam int          OSC_DIV        = 2;
    localparam int          CLK_PERIOD_NS  = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycle kinds requested by the core
    typedef enum logic [1:0] {
        EMB_IDLE  = 2'b00,
        EMB_READ  = 2'b01,
        EMB_WRITE = 2'b10,
        EMB_FETCH = 2'b11
    } emb_kind_t;

    // bus cycle phase
    typedef enum logic [1:0] {
        EMB_PH_IDLE = 2'b00,
        EMB_PH_ADDR = 2'b01,
        EMB_PH_DATA = 2'b10
    } emb_phase_t;

    // request from the core side
    typedef struct packed {
        emb_kind_t   kind;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } emb_req_t;

    // pins facing external memory
    typedef struct packed {
        logic [12:0] addressLines;
        logic [7:0]  dataOut;
        logic        dataOe;
        logic        chipSelN;
        logic        readDirN;
        logic        writeStrobeN;
        logic        dataStrobe;
        logic        fetchStatus;
    } emb_pins_t;

    // whole state of the bus block
    typedef struct packed {
        emb_phase_t  phase;
        emb_kind_t   kind;
        logic        intSel;
        logic        ioUnused;
        logic        divPh;
        emb_pins_t   pins;
        logic [7:0]  rdata;
        logic        done;
        logic [7:0]  syncA;
        logic [7:0]  syncB;
    } emb_state_t;

endpackage

// ==== emb_ext_bus.sv ====
`timescale 1ns/1ps
// What this block does
// - thirteen address outputs cover a flat space of 8192 bytes.
// - separate bidirectional eight-bit data path, never shared with address.
// - page zero holds i/o, timer, 96 ram bytes internal; 128 locations go external.
// - all 7936 addresses above page zero go to the external bus.
// - production rom locations are treated as external and fetched externally.
// - chip select low whenever external ram or i/o is accessed.
// - chip select stays high on the 10 unused i/o locations; address still valid.
// - read-direction low for every read, internal or external; high for writes.
// - internal ram or i/o read data is driven onto the external data bus.
// - write strobe pulses low on external writes with valid data on the bus.
// - data strobe asserted in every read and write while address and data valid.
// - data strobe toggles at half oscillator rate outside wait and stop.
// - fetch status high during opcode fetch cycles, low otherwise.
// - socketed variant: chip select acts as output enable, read-direction as chip select.
// - socketed variant has no write strobe, data strobe or fetch status.
// - bus cycle clock is the oscillator divided by two.
module emb_ext_bus #(
    parameter bit SOCKETED = 1'b0
) (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    input  wire logic            lowPower,
    input  wire emb_pkg::emb_req_t req,
    input  wire logic [7:0]      intRdata,
    input  wire logic [7:0]      dataIn,
    output logic                 reqReady,
    output logic                 intAccess,
    output logic [7:0]           rdata,
    output logic                 rdataValid,
    output emb_pkg::emb_pins_t   pins
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    emb_pkg::emb_state_t s_q;
    emb_pkg::emb_state_t s_d;
    logic                isInt;
    logic                isUnused;
    logic [4:0]          ioIdx;

    // address decode of the request
    always_comb begin
        ioIdx    = req.addr[4:0];
        isInt    = 1'b0;
        isUnused = 1'b0;
        if (req.addr <= emb_pkg::IO_LAST) begin
            isInt    = emb_pkg::IO_USED_MASK[ioIdx];
            isUnused = !emb_pkg::IO_USED_MASK[ioIdx];
        end else if (req.addr >= emb_pkg::RAM_FIRST && req.addr <= emb_pkg::RAM_LAST) begin
            isInt = 1'b1;
        end
        // everything else, rom area included, is external
    end

    assign reqReady = (s_q.phase == emb_pkg::EMB_PH_IDLE) && !s_q.divPh;

    ////////////////////////////////////////////////////////////////////////////////
    // next state: four-clock bus cycle (oscillator divided by two)
    always_comb begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.divPh = !s_q.divPh;
        s_d.syncA = dataIn;
        s_d.syncB = s_q.syncA;
        case (s_q.phase)
            emb_pkg::EMB_PH_IDLE: begin
                s_d.pins.writeStrobeN = 1'b1;
                s_d.pins.dataOe       = 1'b0;
                s_d.pins.chipSelN     = 1'b1;
                s_d.pins.readDirN     = 1'b1;
                s_d.pins.fetchStatus  = 1'b0;
                // external byte has passed both synchroniser stages only now
                if (s_q.kind != emb_pkg::EMB_IDLE) begin
                    s_d.kind = emb_pkg::EMB_IDLE;
                    s_d.done = (s_q.kind != emb_pkg::EMB_WRITE);
                    if (!s_q.intSel) begin
                        s_d.rdata = s_q.syncB;
                    end
                end
                if (reqReady && req.kind != emb_pkg::EMB_IDLE) begin
                    s_d.phase             = emb_pkg::EMB_PH_ADDR;
                    s_d.kind              = req.kind;
                    s_d.intSel            = isInt;
                    s_d.ioUnused          = isUnused;
                    s_d.pins.addressLines = req.addr;
                    s_d.pins.readDirN     = (req.kind == emb_pkg::EMB_WRITE);
                    s_d.pins.chipSelN     = isInt || isUnused;
                    s_d.pins.fetchStatus  = (req.kind == emb_pkg::EMB_FETCH);
                    s_d.pins.dataOut      = req.wdata;
                    s_d.pins.dataOe       = (req.kind == emb_pkg::EMB_WRITE);
                end
            end
            emb_pkg::EMB_PH_ADDR: begin
                s_d.phase = emb_pkg::EMB_PH_DATA;
                if (s_q.kind == emb_pkg::EMB_WRITE) begin
                    // strobe only toward external ram, never on reads
                    s_d.pins.writeStrobeN = s_q.intSel || s_q.ioUnused;
                end else if (s_q.intSel) begin
                    s_d.pins.dataOut = intRdata;
                    s_d.pins.dataOe  = 1'b1;
                end
            end
            emb_pkg::EMB_PH_DATA: begin
                s_d.phase             = emb_pkg::EMB_PH_IDLE;
                s_d.pins.writeStrobeN = 1'b1;
                s_d.pins.dataOe       = 1'b0;
                s_d.pins.chipSelN     = 1'b1;
                s_d.pins.readDirN     = 1'b1;
                s_d.pins.fetchStatus  = 1'b0;
                // internal byte taken while the core still presents it
                if (s_q.intSel) begin
                    s_d.rdata = intRdata;
                end
            end
            default: s_d.phase = emb_pkg::EMB_PH_IDLE;
        endcase
        // strobe runs free at half rate, frozen low in wait or stop
        s_d.pins.dataStrobe = lowPower ? 1'b0 : s_q.divPh;
        if (SOCKETED) begin
            s_d.pins.writeStrobeN = 1'b1;
            s_d.pins.dataStrobe   = 1'b0;
            s_d.pins.fetchStatus  = 1'b0;
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_q                   <= '0;
            s_q.pins.chipSelN     <= 1'b1;
            s_q.pins.readDirN     <= 1'b1;
            s_q.pins.writeStrobeN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; socketed pin roles are the same wires (oe, ce)
    assign pins       = s_q.pins;
    assign rdata      = s_q.rdata;
    assign rdataValid = s_q.done;
    assign intAccess  = s_q.intSel && (s_q.phase != emb_pkg::EMB_PH_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_wr_strobe_only_write;
        @(posedge ref_clk) disable iff (!nrst)
        !pins.writeStrobeN |-> pins.readDirN && !pins.fetchStatus;
    endproperty
    a_wr_strobe_only_write: assert property (p_wr_strobe_only_write) else $error("write strobe outside write");

    property p_cs_external;
        @(posedge ref_clk) disable iff (!nrst)
        !pins.chipSelN |-> !s_q.intSel && !s_q.ioUnused;
    endproperty
    a_cs_external: assert property (p_cs_external) else $error("chip select on internal access");

    property p_cs_unused;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind != emb_pkg::EMB_IDLE && isUnused |=> pins.chipSelN[*2];
    endproperty
    a_cs_unused: assert property (p_cs_unused) else $error("chip select on unused i/o");

    property p_read_dir;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && (req.kind == emb_pkg::EMB_READ || req.kind == emb_pkg::EMB_FETCH) |=> !pins.readDirN[*2];
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("read direction not low on read");

    sequence s_ext_write_start;
        reqReady && req.kind == emb_pkg::EMB_WRITE && !isInt && !isUnused;
    endsequence
    property p_write_pulse;
        @(posedge ref_clk) disable iff (!nrst)
        s_ext_write_start |=> pins.writeStrobeN ##1 (!pins.writeStrobeN || SOCKETED) && pins.dataOe ##1 pins.writeStrobeN;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write strobe pulse wrong");

    property p_int_read_drive;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind == emb_pkg::EMB_READ && isInt |=> ##1 pins.dataOe;
    endproperty
    a_int_read_drive: assert property (p_int_read_drive) else $error("internal read not driven");

    property p_fetch;
        @(posedge ref_clk) disable iff (!nrst)
        pins.fetchStatus |-> s_q.kind == emb_pkg::EMB_FETCH && s_q.phase != emb_pkg::EMB_PH_IDLE;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch status outside fetch");

    property p_ds_toggle;
        @(posedge ref_clk) disable iff (!nrst)
        $past(nrst) && !lowPower && !$past(lowPower) && !SOCKETED |=> pins.dataStrobe != $past(pins.dataStrobe);
    endproperty
    a_ds_toggle: assert property (p_ds_toggle) else $error("data strobe not toggling");

    property p_addr_hold;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.phase == emb_pkg::EMB_PH_ADDR |=> $stable(pins.addressLines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed mid cycle");

    sequence s_any_start;
        reqReady && req.kind != emb_pkg::EMB_IDLE;
    endsequence

    sequence s_read_start;
        reqReady && (req.kind == emb_pkg::EMB_READ || req.kind == emb_pkg::EMB_FETCH);
    endsequence

    sequence s_busy3;
        !reqReady[*3];
    endsequence

    // no request taken inside a bus cycle
    property p_ready_spacing;
        @(posedge ref_clk) disable iff (!nrst)
        s_any_start |=> s_busy3;
    endproperty
    a_ready_spacing: assert property (p_ready_spacing) else $error("request taken mid cycle");

    // next request possible four clocks after the last
    property p_ready_back;
        @(posedge ref_clk) disable iff (!nrst)
        s_any_start |=> ##3 reqReady;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back after cycle");

    // divider flips on every clock
    property p_div_toggle;
        @(posedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> s_q.divPh != $past(s_q.divPh);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divider stuck");

    // read byte handed over once the synchroniser has settled
    property p_read_valid;
        @(posedge ref_clk) disable iff (!nrst)
        s_read_start |=> !rdataValid[*3] ##1 rdataValid;
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read byte not handed over");

    // writes hand nothing back
    property p_write_no_valid;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind == emb_pkg::EMB_WRITE |=> !rdataValid[*4];
    endproperty
    a_write_no_valid: assert property (p_write_no_valid) else $error("valid after write");

    // write strobe is a single clock pulse
    property p_we_single;
        @(posedge ref_clk) disable iff (!nrst)
        !pins.writeStrobeN |=> pins.writeStrobeN;
    endproperty
    a_we_single: assert property (p_we_single) else $error("write strobe too long");

    // write strobe only toward selected memory with data driven
    property p_we_needs_cs;
        @(posedge ref_clk) disable iff (!nrst)
        !pins.writeStrobeN |-> !pins.chipSelN && pins.dataOe;
    endproperty
    a_we_needs_cs: assert property (p_we_needs_cs) else $error("write strobe without select or data");

    // internal locations never select external memory
    property p_int_cs;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind != emb_pkg::EMB_IDLE && isInt |=> pins.chipSelN[*2];
    endproperty
    a_int_cs: assert property (p_int_cs) else $error("select on internal location");

    // external window of page zero selects memory
    property p_page0_ext;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind != emb_pkg::EMB_IDLE && req.addr >= emb_pkg::EXT0_FIRST
            && req.addr <= emb_pkg::EXT0_LAST |=> !pins.chipSelN[*2];
    endproperty
    a_page0_ext: assert property (p_page0_ext) else $error("page zero external not selected");

    // everything above page zero selects memory
    property p_ext_cs;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind != emb_pkg::EMB_IDLE && req.addr > emb_pkg::PAGE0_LAST |=> !pins.chipSelN[*2];
    endproperty
    a_ext_cs: assert property (p_ext_cs) else $error("upper address not selected");

    // opcode fetches from the rom area go out as reads
    property p_rom_fetch;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind == emb_pkg::EMB_FETCH && req.addr > emb_pkg::PAGE0_LAST |=> !pins.chipSelN && !pins.readDirN;
    endproperty
    a_rom_fetch: assert property (p_rom_fetch) else $error("rom fetch not external");

    // address lines carry the requested address
    property p_addr_valid;
        @(posedge ref_clk) disable iff (!nrst)
        s_any_start |=> pins.addressLines == $past(req.addr);
    endproperty
    a_addr_valid: assert property (p_addr_valid) else $error("address lines wrong");

    // unused i/o: address shown, memory not selected
    property p_unused_addr;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind != emb_pkg::EMB_IDLE && isUnused |=> pins.addressLines == $past(req.addr) && pins.chipSelN;
    endproperty
    a_unused_addr: assert property (p_unused_addr) else $error("unused i/o address wrong");

    // direction high through a write cycle
    property p_write_dir;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind == emb_pkg::EMB_WRITE |=> pins.readDirN[*2];
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("direction low on write");

    // bus quiet between cycles
    property p_idle_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.phase == emb_pkg::EMB_PH_IDLE |-> pins.writeStrobeN && pins.chipSelN && !pins.dataOe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus active while idle");

    // device drives a read only when memory is not selected
    property p_bus_no_fight;
        @(posedge ref_clk) disable iff (!nrst)
        pins.dataOe && !pins.readDirN |-> pins.chipSelN;
    endproperty
    a_bus_no_fight: assert property (p_bus_no_fight) else $error("data bus fight on read");

    // strobe high in the data phase, low in the address phase
    property p_ds_in_cycle;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.phase == emb_pkg::EMB_PH_ADDR && !lowPower && !SOCKETED |=> pins.dataStrobe;
    endproperty
    a_ds_in_cycle: assert property (p_ds_in_cycle) else $error("no data strobe in cycle");

    // strobe frozen low in wait or stop
    property p_ds_frozen;
        @(posedge ref_clk) disable iff (!nrst)
        lowPower |=> !pins.dataStrobe;
    endproperty
    a_ds_frozen: assert property (p_ds_frozen) else $error("data strobe runs in low power");

    // fetch status stands through a fetch
    property p_fetch_start;
        @(posedge ref_clk) disable iff (!nrst)
        reqReady && req.kind == emb_pkg::EMB_FETCH |=> (pins.fetchStatus || SOCKETED)[*2];
    endproperty
    a_fetch_start: assert property (p_fetch_start) else $error("fetch status missing");

    // socketed build keeps the absent outputs inactive
    property p_sock_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        SOCKETED |-> pins.writeStrobeN && !pins.dataStrobe && !pins.fetchStatus;
    endproperty
    a_sock_quiet: assert property (p_sock_quiet) else $error("socketed output active");

endmodule

// ==== emb_mem_model.sv ====
`timescale 1ns/1ps
// external memory sitting on the data_lines side of the bus
module emb_mem_model (
    input  wire logic               ref_clk,
    input  wire emb_pkg::emb_pins_t pins,
    input  wire logic [7:0]         busLevel,
    output logic [7:0]              memData
);
    logic [7:0] mem [0:8191];
    logic [7:0] lastQ;

    ////////////////////////////////////////////////////////////////////////////////
    // preload with an address pattern
    initial begin
        lastQ = 8'h00;
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // drive only while selected and reading; released lines keep changing
    always_comb begin
        if (!pins.chipSelN && !pins.readDirN) begin
            memData = mem[pins.addressLines];
        end else begin
            memData = ~lastQ;
        end
    end

    // remember the last level; store while the write strobe is low
    always @(posedge ref_clk) begin
        lastQ <= memData;
        if (!pins.chipSelN && !pins.writeStrobeN) begin
            mem[pins.addressLines] <= busLevel;
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        emb_pkg::emb_kind_t kind;
        logic [12:0]        addr;
        logic [7:0]         wdata;
        logic               csN;
        logic               fs;
    } emb_row_t;

    logic               ref_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               lowPower = 1'b0;
    emb_pkg::emb_req_t  req = '0;
    logic [7:0]         intRdata = 8'h00;
    logic [7:0]         dataIn, rdata, memData;
    logic               reqReady, intAccess, rdataValid, lvl;
    emb_pkg::emb_pins_t pins;
    emb_pkg::emb_pins_t sockPins;
    logic [7:0]         shadow [0:8191];
    emb_row_t           rows [12];
    int                 miscompares = 0;
    int                 n_tests = 0;
    int                 cycles = 0;

    emb_ext_bus u_emb_ext_bus (.ref_clk(ref_clk), .nrst(nrst), .lowPower(lowPower), .req(req), .intRdata(intRdata),
        .dataIn(dataIn), .reqReady(reqReady), .intAccess(intAccess), .rdata(rdata), .rdataValid(rdataValid),
        .pins(pins));
    emb_mem_model u_emb_mem_model (.ref_clk(ref_clk), .pins(pins), .busLevel(dataIn), .memData(memData));
    emb_ext_bus #(.SOCKETED(1'b1)) u_emb_ext_bus_sock (.ref_clk(ref_clk), .nrst(nrst), .lowPower(lowPower), .req(req),
        .intRdata(intRdata), .dataIn(dataIn), .reqReady(), .intAccess(), .rdata(), .rdataValid(), .pins(sockPins));

    ////////////////////////////////////////////////////////////////////////////////
    // wire level, clock and hang guard
    assign dataIn = pins.dataOe ? pins.dataOut : memData;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compares, verdict and bus cycle
    task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp, input string what);
        chkv({15'h0000, got}, {15'h0000, exp}, what);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic run(input emb_row_t r);
        logic rd, intl, unused;
        int   n;
        rd = (r.kind != emb_pkg::EMB_WRITE);
        unused = (r.addr <= emb_pkg::IO_LAST) && !emb_pkg::IO_USED_MASK[r.addr[4:0]];
        intl = r.csN && !unused;
        intRdata = r.addr[7:0] ^ 8'hC3;
        req = '{r.kind, r.addr, r.wdata};
        n = 0;
        while (reqReady !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        tick();
        req.kind = emb_pkg::EMB_IDLE;
        tick();
        chkv(16'(pins.addressLines), 16'(r.addr), "address");
        chkb(pins.chipSelN, r.csN, "select");
        chkb(pins.readDirN, !rd, "direction");
        chkb(pins.fetchStatus, r.fs, "fetch");
        if (!unused) chkb(intAccess, intl, "internal");
        if (rd || !r.csN) chkb(pins.writeStrobeN, rd, "strobe");
        if (!unused) chkb(pins.dataOe, !rd || intl, "drive");
        if (!rd || intl) chkv(16'(pins.dataOut), 16'(rd ? intRdata : r.wdata), "bus data");
        chkb(sockPins.chipSelN, r.csN, "socket enable");
        chkv(16'({sockPins.writeStrobeN, sockPins.dataStrobe, sockPins.fetchStatus}), 16'h0004, "socket");
        tick();
        chkb(pins.chipSelN, 1'b1, "select end");
        chkb(pins.writeStrobeN, 1'b1, "strobe end");
        tick();
        chkb(rdataValid, rd, "valid");
        if (rd && !unused) chkv(16'(rdata), 16'(intl ? intRdata : shadow[r.addr]), "read data");
        if (!rd && !r.csN) shadow[r.addr] = r.wdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        for (int i = 0; i < 8192; i++) begin
            shadow[i] = 8'(i) ^ 8'h5A;
        end
        rows = '{'{emb_pkg::EMB_READ, 13'h0000, 8'h00, 1'b1, 1'b0}, '{emb_pkg::EMB_READ, 13'h0015, 8'h00, 1'b1, 1'b0},
            '{emb_pkg::EMB_READ, 13'h0016, 8'h00, 1'b1, 1'b0}, '{emb_pkg::EMB_READ, 13'h001F, 8'h00, 1'b1, 1'b0},
            '{emb_pkg::EMB_READ, 13'h0020, 8'h00, 1'b0, 1'b0}, '{emb_pkg::EMB_WRITE, 13'h009F, 8'hA5, 1'b0, 1'b0},
            '{emb_pkg::EMB_READ, 13'h009F, 8'h00, 1'b0, 1'b0}, '{emb_pkg::EMB_READ, 13'h00A0, 8'h00, 1'b1, 1'b0},
            '{emb_pkg::EMB_WRITE, 13'h00FF, 8'h3C, 1'b1, 1'b0}, '{emb_pkg::EMB_FETCH, 13'h0100, 8'h00, 1'b0, 1'b1},
            '{emb_pkg::EMB_WRITE, 13'h1FFF, 8'h96, 1'b0, 1'b0}, '{emb_pkg::EMB_FETCH, 13'h1FFF, 8'h00, 1'b0, 1'b1}};
        repeat (16) tick();
        chkb(pins.chipSelN, 1'b1, "reset select");
        chkb(pins.writeStrobeN, 1'b1, "reset strobe");
        nrst = 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
        end
        // strobe runs at half the oscillator rate, frozen in low power
        lvl = pins.dataStrobe;
        tick();
        chkb(pins.dataStrobe, !lvl, "strobe toggle");
        tick();
        chkb(pins.dataStrobe, lvl, "strobe toggle");
        lowPower = 1'b1;
        repeat (2) tick();
        for (int i = 0; i < 4; i++) begin
            chkb(pins.dataStrobe, 1'b0, "strobe frozen");
            tick();
        end
        lowPower = 1'b0;
        // reset dropped in the middle of an external write
        req = '{emb_pkg::EMB_WRITE, 13'h0400, 8'h5A};
        while (reqReady !== 1'b1) begin
            tick();
        end
        repeat (2) tick();
        req.kind = emb_pkg::EMB_IDLE;
        nrst = 1'b0;
        repeat (2) tick();
        chkb(pins.chipSelN, 1'b1, "abort select");
        chkb(pins.writeStrobeN, 1'b1, "abort strobe");
        nrst = 1'b1;
        run(rows[4]);
        close_out();
    end
endmodule
